// file: rtl/tc_regen_pkg.sv
// Shared constants and types for the time code generate/regenerate control
package tc_regen_pkg;
   // Register byte offsets
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_CMD = 5'h04;
   localparam logic [4:0] ADDR_PRESET = 5'h08;
   localparam logic [4:0] ADDR_STATUS = 5'h0c;
   localparam logic [4:0] ADDR_TC = 5'h10;
   // Command register bits (write-one pulses)
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_RESUME = 2;
   localparam int CMD_RESET = 3;
   // Status register bits
   localparam int ST_GEN_MODE = 0;
   localparam int ST_GEN_RUN = 1;
   localparam int ST_LTC_ON = 2;
   localparam int ST_VITC_ON = 3;
   localparam int ST_VITC_REF = 4;
   localparam int ST_MTC_CONT = 5;
   localparam int ST_RATE_ERR = 6;
   localparam int ST_EDIT = 7;
   localparam int ST_LOCK_LSB = 8;
   // Timing
   localparam int CLK_HZ = 125_000_000;
   localparam int MTC_BURST_MS = 200;
   localparam int BLINK_MS = 250;
   localparam int NOMINAL_PCT = 100;
   localparam int LTC_TOL_PCT = 10;
   localparam int MTC_TOL_PCT = 8;
   localparam logic [4:0] HH_MAX = 5'h17;
   localparam logic [5:0] MS_MAX = 6'h3b;

   typedef enum logic [2:0] {POS_GEN, POS_LTC, POS_VITC, POS_BIPH,
      POS_AUTO} pos_ref_t;
   typedef enum logic [2:0] {CLK_INT, CLK_LTC, CLK_PILOT, CLK_BIPH, CLK_AES,
      CLK_WORD, CLK_VREF, CLK_VIN} clk_ref_t;
   typedef enum logic [2:0] {RATE_24, RATE_25, RATE_2997, RATE_2997DF,
      RATE_30, RATE_30DF} rate_t;

   typedef struct packed {
      logic [4:0] hh;
      logic [5:0] mm;
      logic [5:0] ss;
      logic [4:0] ff;
   } tc_t;

   typedef struct packed {
      logic [16:0] rsv3;
      logic vitc_ins;
      logic idle_mute;
      logic pal;
      logic rsv2;
      logic [2:0] rate;
      logic rsv1;
      logic [2:0] clk_ref;
      logic rsv0;
      logic [2:0] pos_ref;
   } ctrl_t;
   localparam logic [31:0] CTRL_RST = 32'h0000_4200;

   // Position reported by the external reader (LTC, VITC or bi-phase)
   typedef struct packed {
      logic valid;
      logic fwd;
      logic [7:0] speed_pct;
      tc_t tc;
   } ext_ref_t;

   typedef struct packed {
      logic ltc_en;
      logic vitc_en;
      logic vitc_ref_path;
      logic mtc_cont;
      logic mtc_burst;
      tc_t tc;
   } tc_out_t;
endpackage : tc_regen_pkg

// file: rtl/tc_sync2.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module tc_sync2 #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_st_t;
   sync_st_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;
endmodule : tc_sync2
`default_nettype wire

// file: rtl/tc_counter.sv
// Up/down time address counter with drop-frame numbering
`timescale 1ns/1ps
`default_nettype none
module tc_counter import tc_regen_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input var tc_t load_val,
   input wire logic step,
   input wire logic down,
   input wire logic drop,
   input wire logic [4:0] fr_max,
   output var tc_t tc
);
   typedef struct packed {
      tc_t tc;
   } cnt_st_t;
   cnt_st_t s_r, s_nxt;
   logic skip;

   always_comb begin
      s_nxt = s_r;
      skip = 1'b0;
      if (load) begin
         s_nxt.tc = load_val;
      end else if (step && !down) begin
         s_nxt.tc.ff = (s_r.tc.ff >= fr_max) ? 5'h00 : s_r.tc.ff + 5'h01;
         if (s_r.tc.ff >= fr_max) begin
            s_nxt.tc.ss = (s_r.tc.ss >= MS_MAX) ? 6'h00 : s_r.tc.ss + 6'h01;
            if (s_r.tc.ss >= MS_MAX) begin
               s_nxt.tc.mm = (s_r.tc.mm >= MS_MAX) ? 6'h00 :
                  s_r.tc.mm + 6'h01;
               if (s_r.tc.mm >= MS_MAX) begin
                  s_nxt.tc.hh = (s_r.tc.hh >= HH_MAX) ? 5'h00 :
                     s_r.tc.hh + 5'h01;
               end
               // Frames 0 and 1 dropped except every tenth minute
               if (drop && (s_nxt.tc.mm % 6'h0a) != 6'h00) begin
                  s_nxt.tc.ff = 5'h02;
               end
            end
         end
      end else if (step && down) begin
         skip = drop && s_r.tc.ss == 6'h00 && (s_r.tc.mm % 6'h0a) != 6'h00;
         if (s_r.tc.ff > (skip ? 5'h02 : 5'h00)) begin
            s_nxt.tc.ff = s_r.tc.ff - 5'h01;
         end else begin
            s_nxt.tc.ff = fr_max;
            s_nxt.tc.ss = (s_r.tc.ss == 6'h00) ? MS_MAX : s_r.tc.ss - 6'h01;
            if (s_r.tc.ss == 6'h00) begin
               s_nxt.tc.mm = (s_r.tc.mm == 6'h00) ? MS_MAX :
                  s_r.tc.mm - 6'h01;
               if (s_r.tc.mm == 6'h00) begin
                  s_nxt.tc.hh = (s_r.tc.hh == 5'h00) ? HH_MAX :
                     s_r.tc.hh - 5'h01;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tc = s_r.tc;
endmodule : tc_counter
`default_nettype wire

// file: rtl/tc_regen_ctrl.sv
// Time code generate/regenerate control with register slave and panel edit
`timescale 1ns/1ps
`default_nettype none
module tc_regen_ctrl import tc_regen_pkg::*; #(
   parameter int FRAME_CYC_24 = CLK_HZ / 24,
   parameter int FRAME_CYC_25 = CLK_HZ / 25,
   parameter int FRAME_CYC_2997 = CLK_HZ / 30000 * 1001,
   parameter int FRAME_CYC_30 = CLK_HZ / 30,
   parameter int BURST_CYC = CLK_HZ / 1000 * MTC_BURST_MS,
   parameter int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input var ext_ref_t ext_ref,
   input wire logic biph_frame,
   input wire logic [7:0] ref_tick,
   input wire logic btn_up_pin,
   input wire logic btn_down_pin,
   input wire logic btn_set_pin,
   input var tc_t nv_preset_in,
   output logic nv_wr,
   output var tc_t nv_preset_out,
   output logic [3:0] flash_field,
   output var tc_out_t tc_out
);
   typedef struct packed {
      ctrl_t ctrl;
      tc_t preset;
      logic ack;
      logic [31:0] rdata;
      logic run;
      logic nv_loaded;
      logic nv_wr;
      logic [22:0] div;
      logic [24:0] burst;
      logic [24:0] blink_cnt;
      logic blink;
      logic edit;
      logic [1:0] field;
      logic up_seen;
      logic dn_seen;
      logic set_prev;
      tc_out_t out;
   } st_t;
   st_t s_r, s_nxt;

   logic [2:0] btn;
   logic bus_req;
   logic [3:0] cmd;
   logic gen_mode, biph_mode, video_clk, rate_err, drop;
   logic int_tick, lock_tick, gen_step, gen_load, ext_mode;
   logic fwd_ltc, fwd_mtc, ltc_on, vitc_on, mtc_cont_on, burst_ok;
   logic [4:0] fr_max;
   logic [22:0] period;
   logic [2:0] lock_src;
   tc_t gen_tc, biph_tc, gen_load_val, sel_tc;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [5:0] bump(input logic [5:0] v,
      input logic [5:0] vmax, input logic up);
      logic [5:0] r;
      if (up) begin
         r = (v >= vmax) ? 6'h00 : v + 6'h01;
      end else begin
         r = (v == 6'h00) ? vmax : v - 6'h01;
      end
      return r;
   endfunction : bump

   function automatic logic in_tol(input logic [7:0] pct, input int tol);
      return (int'(pct) >= NOMINAL_PCT - tol) &&
         (int'(pct) <= NOMINAL_PCT + tol);
   endfunction : in_tol

   tc_sync2 #(.W(3)) u_btn_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({btn_set_pin, btn_down_pin, btn_up_pin}),
      .q(btn)
   );

   assign bus_req = avs_read || avs_write;
   assign avs_waitrequest = bus_req && !s_r.ack;
   assign cmd = (avs_write && !s_r.ack && avs_address == ADDR_CMD) ?
      avs_writedata[3:0] & {4{avs_byteenable[0]}} : 4'h0;

   // Mode decode
   assign gen_mode = s_r.ctrl.pos_ref == POS_GEN;
   assign biph_mode = s_r.ctrl.pos_ref == POS_BIPH;
   assign ext_mode = !gen_mode;
   assign video_clk = s_r.ctrl.clk_ref == CLK_VREF ||
      s_r.ctrl.clk_ref == CLK_VIN;
   assign drop = s_r.ctrl.rate == RATE_2997DF || s_r.ctrl.rate == RATE_30DF;

   // Video-derived rate limits apply only in generator mode
   always_comb begin
      rate_err = 1'b0;
      if (gen_mode && video_clk) begin
         if (s_r.ctrl.pal) begin
            rate_err = s_r.ctrl.rate != RATE_25;
         end else begin
            rate_err = s_r.ctrl.rate != RATE_2997 &&
               s_r.ctrl.rate != RATE_2997DF;
         end
      end
   end

   // Nominal frame period; no pull factor exists in this path
   always_comb begin
      case (s_r.ctrl.rate)
         RATE_24: begin
            period = 23'(FRAME_CYC_24 - 1);
            fr_max = 5'h17;
         end
         RATE_25: begin
            period = 23'(FRAME_CYC_25 - 1);
            fr_max = 5'h18;
         end
         RATE_2997, RATE_2997DF: begin
            period = 23'(FRAME_CYC_2997 - 1);
            fr_max = 5'h1d;
         end
         default: begin
            period = 23'(FRAME_CYC_30 - 1);
            fr_max = 5'h1d;
         end
      endcase
   end

   assign int_tick = s_r.div == 23'h0;
   // Both video inputs resolve to the reference video connector
   assign lock_src = video_clk ? 3'(CLK_VREF) : s_r.ctrl.clk_ref;
   assign lock_tick = (lock_src == 3'(CLK_INT)) ? int_tick :
      ref_tick[lock_src];

   assign gen_load = !s_r.nv_loaded || cmd[CMD_START] || cmd[CMD_RESET];
   assign gen_load_val = s_r.nv_loaded ? s_r.preset : nv_preset_in;
   assign gen_step = gen_mode && s_r.run && lock_tick && !rate_err;

   tc_counter u_gen_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .load(gen_load),
      .load_val(gen_load_val),
      .step(gen_step),
      .down(1'b0),
      .drop(drop),
      .fr_max(fr_max),
      .tc(gen_tc)
   );

   // Bi-phase position sits at the preset until bi-phase is selected
   tc_counter u_biph_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .load(!biph_mode),
      .load_val(s_r.preset),
      .step(biph_mode && biph_frame),
      .down(!ext_ref.fwd),
      .drop(drop),
      .fr_max(fr_max),
      .tc(biph_tc)
   );

   // Output address source and enables
   always_comb begin
      if (gen_mode) begin
         sel_tc = gen_tc;
      end else if (biph_mode) begin
         sel_tc = biph_tc;
      end else begin
         sel_tc = ext_ref.tc;
      end
   end

   assign fwd_ltc = ext_ref.fwd && in_tol(ext_ref.speed_pct, LTC_TOL_PCT);
   assign fwd_mtc = ext_ref.fwd && in_tol(ext_ref.speed_pct, MTC_TOL_PCT);
   assign ltc_on = gen_mode ? s_r.run :
      (ext_ref.valid && fwd_ltc);
   assign vitc_on = s_r.ctrl.vitc_ins && (gen_mode || (ext_ref.valid &&
      (s_r.ctrl.pos_ref == POS_LTC || biph_mode)));
   assign mtc_cont_on = gen_mode ? s_r.run :
      (ext_ref.valid && fwd_mtc);
   assign burst_ok = (!ext_mode || ext_ref.valid) && !mtc_cont_on &&
      !(s_r.ctrl.idle_mute && !ltc_on);

   always_comb begin
      s_nxt = s_r;
      s_nxt.nv_wr = 1'b0;
      s_nxt.nv_loaded = 1'b1;
      if (!s_r.nv_loaded) begin
         s_nxt.preset = nv_preset_in;
      end

      // Register slave: answer one cycle after the request
      s_nxt.ack = bus_req && !s_r.ack;
      if (bus_req && !s_r.ack) begin
         s_nxt.rdata = 32'h0;
         if (avs_read) begin
            case (avs_address)
               ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
               ADDR_PRESET: s_nxt.rdata = 32'(s_r.preset);
               ADDR_STATUS: begin
                  s_nxt.rdata[ST_GEN_MODE] = gen_mode;
                  s_nxt.rdata[ST_GEN_RUN] = s_r.run;
                  s_nxt.rdata[ST_LTC_ON] = s_r.out.ltc_en;
                  s_nxt.rdata[ST_VITC_ON] = s_r.out.vitc_en;
                  s_nxt.rdata[ST_VITC_REF] = s_r.out.vitc_ref_path;
                  s_nxt.rdata[ST_MTC_CONT] = s_r.out.mtc_cont;
                  s_nxt.rdata[ST_RATE_ERR] = rate_err;
                  s_nxt.rdata[ST_EDIT] = s_r.edit;
                  s_nxt.rdata[ST_LOCK_LSB +: 3] = lock_src;
               end
               ADDR_TC: s_nxt.rdata = 32'(s_r.out.tc);
               default: s_nxt.rdata = 32'h0;
            endcase
         end else begin
            case (avs_address)
               ADDR_CTRL: begin
                  s_nxt.ctrl = merge(s_r.ctrl, avs_writedata,
                     avs_byteenable) & CTRL_RST | merge(s_r.ctrl,
                     avs_writedata, avs_byteenable) & 32'h0000_7777;
               end
               ADDR_PRESET: begin
                  s_nxt.preset = tc_t'(22'(merge(32'(s_r.preset),
                     avs_writedata, avs_byteenable)));
                  s_nxt.nv_wr = 1'b1;
               end
               default: ;
            endcase
         end
      end

      // Generator run control
      if (cmd[CMD_START] || cmd[CMD_RESUME]) begin
         s_nxt.run = 1'b1;
      end
      if (cmd[CMD_STOP] || cmd[CMD_RESET]) begin
         s_nxt.run = 1'b0;
      end

      s_nxt.div = int_tick ? period : s_r.div - 23'h1;

      // Burst MTC pacing
      s_nxt.out.mtc_burst = 1'b0;
      if (!burst_ok) begin
         s_nxt.burst = 25'h0;
      end else if (s_r.burst == 25'h0) begin
         s_nxt.out.mtc_burst = 1'b1;
         s_nxt.burst = 25'(BURST_CYC - 1);
      end else begin
         s_nxt.burst = s_r.burst - 25'h1;
      end

      s_nxt.out.ltc_en = ltc_on;
      s_nxt.out.vitc_en = vitc_on;
      s_nxt.out.vitc_ref_path = gen_mode && video_clk;
      s_nxt.out.mtc_cont = mtc_cont_on;
      s_nxt.out.tc = sel_tc;

      // Panel preset editing
      if (s_r.blink_cnt == 25'h0) begin
         s_nxt.blink_cnt = 25'(BLINK_CYC - 1);
         s_nxt.blink = !s_r.blink;
      end else begin
         s_nxt.blink_cnt = s_r.blink_cnt - 25'h1;
      end
      s_nxt.set_prev = btn[2];
      if (btn[2] && !s_r.set_prev) begin
         s_nxt.edit = !s_r.edit;
         s_nxt.field = 2'h0;
         s_nxt.nv_wr = s_nxt.nv_wr || s_r.edit;
      end else if (s_r.edit) begin
         s_nxt.up_seen = s_r.up_seen || btn[0];
         s_nxt.dn_seen = s_r.dn_seen || btn[1];
         if (!btn[0] && !btn[1] && (s_r.up_seen || s_r.dn_seen)) begin
            s_nxt.up_seen = 1'b0;
            s_nxt.dn_seen = 1'b0;
            if (s_r.up_seen && s_r.dn_seen) begin
               s_nxt.field = s_r.field + 2'h1;
            end else begin
               case (s_r.field)
                  2'h0: s_nxt.preset.hh = 5'(bump(6'(s_r.preset.hh),
                     6'(HH_MAX), s_r.up_seen));
                  2'h1: s_nxt.preset.mm = bump(s_r.preset.mm, MS_MAX,
                     s_r.up_seen);
                  2'h2: s_nxt.preset.ss = bump(s_r.preset.ss, MS_MAX,
                     s_r.up_seen);
                  default: s_nxt.preset.ff = 5'(bump(6'(s_r.preset.ff),
                     6'(fr_max), s_r.up_seen));
               endcase
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avs_readdata = s_r.rdata;
   assign nv_wr = s_r.nv_wr;
   assign nv_preset_out = s_r.preset;
   assign flash_field = (s_r.edit && s_r.blink) ?
      4'(4'h8 >> s_r.field) : 4'h0;
   assign tc_out = s_r.out;
endmodule : tc_regen_ctrl
`default_nettype wire

// file: test/tc_regen_ctrl_asserts.sv
// Property checks on the time code control block ports
`timescale 1ns/1ps
`default_nettype none
module tc_regen_ctrl_asserts import tc_regen_pkg::*; #(
   parameter int BURST_CYC = 100
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input var ext_ref_t ext_ref,
   input wire logic nv_wr,
   input var tc_out_t tc_out
);
   ctrl_t c_r;
   logic [1:0] q_r;
   logic [9:0] gap_r;
   logic seen_r, qt, ext, ok10, ok8, mv;
   // Control copy is trusted only three cycles after a write
   assign qt = q_r == 2'h3;
   assign ext = c_r.pos_ref != POS_GEN;
   assign mv = ext_ref.valid && ext_ref.fwd;
   assign ok10 = mv && ext_ref.speed_pct >= 8'h5a && ext_ref.speed_pct <= 8'h6e;
   assign ok8 = mv && ext_ref.speed_pct >= 8'h5c && ext_ref.speed_pct <= 8'h6c;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         c_r <= CTRL_RST;
         q_r <= 2'h0;
         gap_r <= 10'h0;
         seen_r <= 1'b0;
      end else begin
         if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL) begin
            for (int i = 0; i < 4; i++) begin
               if (avs_byteenable[i]) begin
                  c_r[i*8 +: 8] <= avs_writedata[i*8 +: 8];
               end
            end
            q_r <= 2'h0;
         end else if (!qt) begin
            q_r <= q_r + 2'h1;
         end
         gap_r <= tc_out.mtc_burst ? 10'h0 : gap_r + {9'h0, gap_r != 10'h3ff};
         // Burst pacing restarts whenever bursting was not allowed
         seen_r <= qt && !tc_out.mtc_cont && (!ext || ext_ref.valid) &&
            !(c_r.idle_mute && !tc_out.ltc_en) &&
            (seen_r || tc_out.mtc_burst);
      end
   end
   ltc_window_a: assert property (qt && ext |-> tc_out.ltc_en == $past(ok10))
      else $error("ltc enable off the speed window");
   mtc_window_a: assert property (qt && ext |-> tc_out.mtc_cont == $past(ok8))
      else $error("continuous mtc off the speed window");
   vitc_block_a: assert property (qt && (c_r.pos_ref == POS_VITC
      || c_r.pos_ref == POS_AUTO) |-> !tc_out.vitc_en)
      else $error("vitc inserted over read vitc");
   vitc_path_a: assert property (qt && tc_out.vitc_en |-> tc_out.vitc_ref_path
      == (c_r.pos_ref == POS_GEN && c_r.clk_ref[2:1] == 2'h3))
      else $error("vitc on wrong video path");
   tc_follow_a: assert property (qt && $past(ext_ref.valid) && (c_r.pos_ref
      == POS_LTC || c_r.pos_ref == POS_VITC) |-> tc_out.tc == $past(ext_ref.tc))
      else $error("output address differs from input");
   burst_gap_a: assert property (tc_out.mtc_burst && seen_r |-> gap_r >= BURST_CYC - 1)
      else $error("mtc bursts too close");
   burst_mute_a: assert property (qt && c_r.idle_mute && !tc_out.ltc_en
      |-> !tc_out.mtc_burst)
      else $error("muted burst emitted");
   bus_wait_a: assert property ($rose(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait state");
   nv_store_a: assert property (avs_write && avs_waitrequest
      && avs_address == ADDR_PRESET |-> ##[1:3] nv_wr)
      else $error("preset write not stored");
endmodule : tc_regen_ctrl_asserts
bind tc_regen_ctrl tc_regen_ctrl_asserts #(.BURST_CYC(BURST_CYC)) i_chk (
   .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_waitrequest, .ext_ref, .nv_wr, .tc_out);
`default_nettype wire

// file: test/tc_reader_model.sv
// Tape reader and clock reference sources facing the control block
`timescale 1ns/1ps
`default_nettype none
module tc_reader_model import tc_regen_pkg::*; #(
   parameter int FR = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic valid,
   input wire logic fwd,
   input wire logic [7:0] speed,
   output var ext_ref_t ext_ref,
   output logic biph_frame,
   output logic [7:0] ref_tick
);
   int cnt;
   logic [4:0] ff;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         ff <= 5'h0;
         ext_ref <= '0;
         biph_frame <= 1'b0;
         ref_tick <= 8'h0;
      end else begin
         cnt <= cnt == FR - 1 ? 0 : cnt + 1;
         ref_tick <= cnt == 0 ? 8'hfe : 8'h0;
         biph_frame <= cnt == 0 && valid;
         if (cnt == 0 && valid) begin
            ff <= fwd ? (ff == 5'h1d ? 5'h0 : ff + 5'h1)
               : (ff == 5'h0 ? 5'h1d : ff - 5'h1);
         end
         ext_ref.valid <= valid;
         ext_ref.fwd <= fwd;
         // Lost signal shows a pattern that changes every cycle
         ext_ref.speed_pct <= valid ? speed : ~ext_ref.speed_pct;
         ext_ref.tc <= valid ? {5'h1, 6'h2, 6'h3, ff} : ~ext_ref.tc;
      end
   end
endmodule : tc_reader_model
`default_nettype wire

// file: test/tc_regen_ctrl_tb_top.sv
// Self-checking bench for the time code control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module tc_regen_ctrl_tb_top import tc_regen_pkg::*; ;
   localparam int BC = 100;
   localparam tc_t NV0 = {5'h2, 6'h4, 6'h6, 5'h8};
   logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic v = 1'b0, f = 1'b1, btn_up = 1'b0, btn_down = 1'b0, btn_set = 1'b0;
   logic [4:0] avs_address = 5'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq;
   logic avs_waitrequest, biph_frame, nv_wr;
   logic [7:0] ref_tick, sp = 8'h64;
   logic [3:0] flash_field, be = 4'hf;
   logic [15:0] rt [8] = '{16'h8060, 16'h1170, 16'h0360, 16'h8460,
      16'h8160, 16'h0061, 16'h0000, 16'h9060};
   tc_t gq[$] = '{{5'h0, 6'h0, 6'h3b, 5'h1d}, {5'h0, 6'h1, 6'h0, 5'h2},
      {5'h0, 6'h9, 6'h3b, 5'h1d}, {5'h0, 6'ha, 6'h0, 5'h0},
      {5'h0, 6'h0, 6'h3b, 5'h1d}, {5'h0, 6'h1, 6'h0, 5'h0}};
   tc_t nv_out, t0;
   ext_ref_t ext_ref;
   tc_out_t tc_out;
   int n_mismatch = 0, n_tests = 0, seed = 32'hcc8263cf, cnt, e;
   tc_regen_ctrl #(.FRAME_CYC_24(30), .FRAME_CYC_25(30), .FRAME_CYC_2997(40),
      .FRAME_CYC_30(30), .BURST_CYC(BC), .BLINK_CYC(8)) i_dut (
      .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .ext_ref,
      .biph_frame, .ref_tick, .btn_up_pin(btn_up), .btn_down_pin(btn_down),
      .btn_set_pin(btn_set), .nv_preset_in(NV0), .nv_wr,
      .nv_preset_out(nv_out), .flash_field, .tc_out);
   tc_reader_model i_rdr (.core_clk, .rst, .valid(v), .fwd(f), .speed(sp),
      .ext_ref, .biph_frame, .ref_tick);
   initial forever #4 core_clk = ~core_clk;
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rdq = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic press(input logic [2:0] m);
      @(posedge core_clk);
      {btn_set, btn_down, btn_up} <= m;
      repeat (4) @(posedge core_clk);
      {btn_set, btn_down, btn_up} <= 3'h0;
      repeat (6) @(posedge core_clk);
   endtask : press
   // Reference speed window expectations: {ltc, continuous mtc}
   function automatic logic [1:0] mdl(input int s, input logic vv, ww);
      mdl = {vv && ww && s >= 90 && s <= 110, vv && ww && s >= 92 && s <= 108};
   endfunction : mdl
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   initial begin
      #400000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rd(ADDR_CTRL);
      `CHK(rdq, CTRL_RST)
      rd(ADDR_PRESET);
      `CHK(rdq[21:0], NV0)
      rd(5'h14);
      `CHK(rdq, 32'h0)
      wr(ADDR_CTRL, 32'hffff_ffff);
      rd(ADDR_CTRL);
      `CHK(rdq, 32'h0000_7777)
      be <= 4'h1;
      wr(ADDR_CTRL, 32'h0);
      be <= 4'hf;
      rd(ADDR_CTRL);
      `CHK(rdq, 32'h0000_7700)
      $display("test registers done");
      wr(ADDR_CTRL, 32'h4201);
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         sp <= i < 8 ? 8'(i < 4 ? 89 + i : 104 + i)
            : 8'(80 + $unsigned($random(seed)) % 41);
         f <= i % 5 != 4;
         v <= i % 4 != 3;
         @(posedge core_clk iff ref_tick[1]);
         repeat (4) @(posedge core_clk);
         e = mdl(sp, v, f);
         `CHK(tc_out.ltc_en, e[1])
         `CHK(tc_out.mtc_cont, e[0])
         if (v) `CHK(tc_out.tc, ext_ref.tc)
      end
      $display("test speed done");
      v <= 1'b1;
      f <= 1'b0;
      sp <= 8'h32;
      for (int p = 0; p < 5; p++) begin
         for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTRL, 32'(32'h4200 | c << 4 | p));
            repeat (4) @(posedge core_clk);
            if (p != 0) `CHK(tc_out.vitc_en, p == 1 || p == 3)
            if (tc_out.vitc_en === 1'b1) `CHK(tc_out.vitc_ref_path, p == 0 && c > 5)
            rd(ADDR_STATUS);
            if (p == 0) `CHK(rdq[10:8], 3'(c == 7 ? 6 : c))
         end
      end
      $display("test vitc done");
      foreach (rt[k]) begin
         wr(ADDR_CTRL, {16'h0, rt[k] & 16'h7fff | 16'h4000});
         rd(ADDR_STATUS);
         `CHK(rdq[ST_RATE_ERR], rt[k][15])
      end
      $display("test rates done");
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CTRL, k < 2 ? 32'h4300 : 32'h4200);
         wr(ADDR_PRESET, {10'h0, gq[2 * k]});
         wr(ADDR_CMD, 32'h8);
         rd(ADDR_TC);
         `CHK(rdq[21:0], gq[2 * k])
         wr(ADDR_CMD, 32'h1);
         cnt = 0;
         do begin
            rd(ADDR_TC);
            cnt++;
         end while (rdq[21:0] === gq[2 * k] && cnt < 60);
         `CHK(rdq[21:0], gq[2 * k + 1])
      end
      wr(ADDR_CMD, 32'h2);
      rd(ADDR_TC);
      t0 = rdq[21:0];
      repeat (100) @(posedge core_clk);
      rd(ADDR_TC);
      `CHK(rdq[21:0], t0)
      `CHK(tc_out.tc, t0)
      wr(ADDR_CMD, 32'h4);
      repeat (100) @(posedge core_clk);
      rd(ADDR_TC);
      `CHK(rdq[21:0] !== t0, 1'b1)
      $display("test generator done");
      wr(ADDR_CTRL, 32'h4202);
      for (int m = 0; m < 2; m++) begin
         cnt = 0;
         for (int i = 0; i < 2 * BC && tc_out.mtc_burst !== 1'b1; i++) @(posedge core_clk);
         repeat (5 * BC) begin
            @(posedge core_clk);
            cnt += tc_out.mtc_burst === 1'b1;
         end
         `CHK(cnt, m ? 0 : 5)
         wr(ADDR_CTRL, 32'h6202);
      end
      $display("test bursts done");
      v <= 1'b0;
      wr(ADDR_CTRL, 32'h4203);
      rd(ADDR_TC);
      `CHK(rdq[21:0], gq[4])
      v <= 1'b1;
      f <= 1'b1;
      @(posedge core_clk iff biph_frame);
      rd(ADDR_TC);
      `CHK(rdq[21:0], gq[5])
      $display("test biphase done");
      wr(ADDR_PRESET, {10'h0, 5'h1, 6'h2, 6'h3, 5'h4});
      t0 = nv_out;
      press(3'h4);
      cnt = 0;
      repeat (40) begin
         @(posedge core_clk);
         cnt += $onehot(flash_field);
      end
      `CHK(cnt > 0 && cnt < 40, 1'b1)
      press(3'h1);
      press(3'h4);
      repeat (20) @(posedge core_clk);
      e = nv_out - t0;
      `CHK(e == 1 || e == 32 || e == 2048 || e == 131072, 1'b1)
      $display("test panel done");
      test_done();
   end
endmodule : tc_regen_ctrl_tb_top
`default_nettype wire
